//--- rtl/ahc_core.sv
`include "ahc_params.svh"
`default_nettype none

module ahc_core #(
    parameter int POWERUP_CYC = `AHC_POWERUP_CYC,
    parameter int RESET_WAIT = `AHC_RESET_WAIT_CLK,
    parameter int FIFO_DEPTH = `AHC_FIFO_DEPTH,
    parameter logic [7:0] ID_VALUE = `AHC_ID_VALUE
) (
    // system clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic data_out_ready_pin,
    output logic data_out_ready_oe,
    // control pins
    input wire logic start_sync_pin,
    output logic result_ready_n,
    // converter result stream
    input wire ahc_pkg::ahc_word_t result_data,
    input wire logic result_valid,
    output logic result_accept,
    output logic conv_run,
    // general-purpose pins
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe
);
    import ahc_pkg::*;

    localparam int NREGS = `AHC_NREGS;
    localparam int NSYNC = 4 + NREGS + 1;

    // link domain
    logic link_rst_n;
    ahc_link_st_t link_st_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] rx_reg;
    ahc_byte_t rx_byte;
    logic [4:0] addr_reg;
    logic [4:0] cnt_reg;
    logic rd_mode_reg;
    logic rd_half_reg;
    logic [15:0] tx_reg;
    logic rst_tog_reg;
    logic start_tog_reg;
    logic stop_tog_reg;
    logic done_tog_reg;
    logic [NREGS-1:0] wr_tog_reg;
    ahc_byte_t wr_dat_reg [NREGS];
    ahc_byte_t rd_byte;

    // system domain
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] sync_lvl;
    logic [NSYNC-2:0] lvl_d_reg;
    logic [NSYNC-2:0] ev;
    logic rst_ev;
    logic start_ev;
    logic stop_ev;
    logic done_ev;
    logic [NREGS-1:0] wr_ev;
    logic start_pin_lvl;
    ahc_byte_t cfg_reg [NREGS];
    logic por_flag_reg;
    logic [14:0] ready_cnt_reg;
    logic converting_reg;
    ahc_word_t result_word_reg;
    logic result_ready_n_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    ahc_word_t fifo_out_data;

    function automatic logic reg_mapped(input logic [4:0] a);
        reg_mapped = (a[4:3] == 2'b00);
    endfunction

    function automatic ahc_byte_t reg_view(input logic [4:0] a);
        ahc_byte_t v;
        v = '0;
        if (!reg_mapped(a)) begin
            v = '0;
        end else if (a[2:0] == `AHC_REG_ID) begin
            v = ID_VALUE;
        end else if (a[2:0] == `AHC_REG_STATUS) begin
            v[`AHC_ST_POR_BIT] = por_flag_reg;
            v[`AHC_ST_RDYN_BIT] = (ready_cnt_reg != '0);
        end else begin
            v = cfg_reg[a[2:0]];
        end
        return v;
    endfunction

    // ---------------- link side, clocked by sclk ----------------

    assign link_rst_n = nrst & ~cs_n;
    assign rx_byte = {rx_reg, din};

    // commands sampled on the falling edge
    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_st_reg <= ls_cmd;
            bit_cnt_reg <= 3'h0;
            rx_reg <= 7'h00;
            addr_reg <= 5'h00;
            cnt_reg <= 5'h00;
            rd_mode_reg <= 1'b0;
            rd_half_reg <= 1'b0;
        end else begin
            rx_reg <= rx_byte[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
                case (link_st_reg)
                    ls_cmd: begin
                        if (rx_byte == `AHC_OP_RDATA) begin
                            link_st_reg <= ls_rdata;
                        end else if (rx_byte[7:5] == `AHC_OP_REGISTER_READ_CMD) begin
                            addr_reg <= rx_byte[4:0];
                            rd_mode_reg <= 1'b1;
                            link_st_reg <= ls_arg;
                        end else if (rx_byte[7:5] == `AHC_OP_REGISTER_WRITE_CMD) begin
                            addr_reg <= rx_byte[4:0];
                            rd_mode_reg <= 1'b0;
                            link_st_reg <= ls_arg;
                        end
                    end
                    ls_arg: begin
                        cnt_reg <= rx_byte[4:0];
                        link_st_reg <= rd_mode_reg ? ls_register_read_cmd : ls_wdata;
                    end
                    ls_wdata, ls_register_read_cmd: begin
                        addr_reg <= addr_reg + 5'h01;
                        cnt_reg <= cnt_reg - 5'h01;
                        if (cnt_reg == 5'h00) begin
                            link_st_reg <= ls_cmd;
                        end
                    end
                    ls_rdata: begin
                        rd_half_reg <= ~rd_half_reg;
                        if (rd_half_reg) begin
                            link_st_reg <= ls_hold;
                        end
                    end
                    ls_hold: begin
                        link_st_reg <= ls_hold;
                    end
                    default: begin
                        link_st_reg <= ls_cmd;
                    end
                endcase
            end
        end
    end

    // toggles survive deselect so no false event is made
    always_ff @(negedge sclk or negedge nrst) begin
        if (!nrst) begin
            rst_tog_reg <= 1'b0;
            start_tog_reg <= 1'b0;
            stop_tog_reg <= 1'b0;
            done_tog_reg <= 1'b0;
            wr_tog_reg <= '0;
            for (int i = 0; i < NREGS; i++) begin
                wr_dat_reg[i] <= `AHC_REG_RST;
            end
        end else if (link_rst_n && bit_cnt_reg == 3'h7) begin
            if (link_st_reg == ls_cmd) begin
                if (rx_byte == `AHC_OP_RESET) begin
                    rst_tog_reg <= ~rst_tog_reg;
                end
                if (rx_byte == `AHC_OP_START) begin
                    start_tog_reg <= ~start_tog_reg;
                end
                if (rx_byte == `AHC_OP_STOP) begin
                    stop_tog_reg <= ~stop_tog_reg;
                end
            end
            if (link_st_reg == ls_wdata && reg_mapped(addr_reg)) begin
                wr_dat_reg[addr_reg[2:0]] <= rx_byte;
                wr_tog_reg[addr_reg[2:0]] <= ~wr_tog_reg[addr_reg[2:0]];
            end
            if (link_st_reg == ls_rdata && rd_half_reg) begin
                done_tog_reg <= ~done_tog_reg;
            end
        end
    end

    // read data is combinational: follows addr_reg as it steps and the live registers
    assign rd_byte = reg_view(addr_reg);

    // data out changes on the rising edge
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_reg <= 16'h0000;
        end else if (bit_cnt_reg == 3'h0 && link_st_reg == ls_register_read_cmd) begin
            tx_reg <= {rd_byte, 8'h00};
        end else if (bit_cnt_reg == 3'h0 && link_st_reg == ls_rdata &&
                     !rd_half_reg) begin
            // msb first from the held result
            tx_reg <= result_word_reg;
        end else if (link_st_reg != ls_hold) begin
            tx_reg <= {tx_reg[14:0], 1'b0};
        end
    end

    // combined pin: result or register bits while reading, else ready
    assign data_out_ready_pin =
        (link_st_reg == ls_rdata || link_st_reg == ls_register_read_cmd ||
         link_st_reg == ls_hold) ? tx_reg[15] : result_ready_n_reg;
    assign data_out_ready_oe = ~cs_n;

    // ---------------- system side, clocked by mclk ----------------

    assign sync_in = {start_sync_pin, done_tog_reg, stop_tog_reg,
                      start_tog_reg, rst_tog_reg, wr_tog_reg};

    ahc_sync3 #(
        .W(NSYNC)
    ) u_sync (
        .clk(mclk),
        .rst_n(nrst),
        .d(sync_in),
        .q(sync_lvl)
    );

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lvl_d_reg <= '0;
        end else begin
            lvl_d_reg <= sync_lvl[NSYNC-2:0];
        end
    end

    assign ev = sync_lvl[NSYNC-2:0] ^ lvl_d_reg;
    assign wr_ev = ev[NREGS-1:0];
    assign rst_ev = ev[NREGS];
    assign start_ev = ev[NREGS+1];
    assign stop_ev = ev[NREGS+2];
    assign done_ev = ev[NREGS+3];
    assign start_pin_lvl = sync_lvl[NSYNC-1];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NREGS; i++) begin
                cfg_reg[i] <= `AHC_REG_RST;
            end
        end else if (rst_ev) begin
            for (int i = 0; i < NREGS; i++) begin
                cfg_reg[i] <= `AHC_REG_RST;
            end
        end else begin
            for (int i = 0; i < NREGS; i++) begin
                if (wr_ev[i] && i[2:0] != `AHC_REG_ID &&
                    i[2:0] != `AHC_REG_STATUS) begin
                    cfg_reg[i] <= wr_dat_reg[i];
                end
            end
        end
    end

    // write of 00h clears the flag; a reset sets it and wins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            por_flag_reg <= 1'b1;
        end else if (rst_ev) begin
            por_flag_reg <= 1'b1;
        end else if (wr_ev[`AHC_REG_STATUS] &&
                     wr_dat_reg[`AHC_REG_STATUS] == `AHC_STATUS_CLEAR) begin
            por_flag_reg <= 1'b0;
        end
    end

    // not ready through the power-up wait
    // not ready through the post-reset wait
    // ready bit reads 0 when the count is done
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ready_cnt_reg <= 15'(POWERUP_CYC);
        end else if (rst_ev) begin
            ready_cnt_reg <= 15'(RESET_WAIT);
        end else if (ready_cnt_reg != '0) begin
            ready_cnt_reg <= ready_cnt_reg - 15'h0001;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            converting_reg <= 1'b0;
        end else if (rst_ev || stop_ev) begin
            converting_reg <= 1'b0;
        end else if (start_ev) begin
            converting_reg <= 1'b1;
        end
    end

    // a low start pin leaves control to the commands
    assign conv_run = converting_reg | start_pin_lvl;
    assign result_accept = fifo_in_ready & conv_run;

    ahc_fifo #(
        .WIDTH(`AHC_RESULT_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst_n(nrst),
        .clr(rst_ev),
        .in_valid(result_valid & conv_run),
        .in_ready(fifo_in_ready),
        .in_data(result_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // a word is only replaced while the ready line is high
    assign fifo_pop = fifo_out_valid & result_ready_n_reg & ~rst_ev;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            result_word_reg <= 16'h0000;
        end else if (fifo_pop) begin
            result_word_reg <= fifo_out_data;
        end
    end

    // ready falls on a new word, rises once it is read
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            result_ready_n_reg <= 1'b1;
        end else if (rst_ev || done_ev) begin
            result_ready_n_reg <= 1'b1;
        end else if (fifo_pop) begin
            result_ready_n_reg <= 1'b0;
        end
    end

    assign result_ready_n = result_ready_n_reg;

    // pin levels follow the data register, enables the config register, default 0
    assign gpio_out = cfg_reg[`AHC_REG_GPIO_DAT][3:0];
    assign gpio_oe = cfg_reg[`AHC_REG_GPIO_CFG][3:0];
endmodule // ahc_core

`default_nettype wire

//--- rtl/ahc_params.svh
`ifndef AHC_PARAMS_SVH
`define AHC_PARAMS_SVH

// command opcodes
`define AHC_OP_RESET 8'h06
`define AHC_OP_START 8'h08
`define AHC_OP_STOP 8'h0a
`define AHC_OP_RDATA 8'h12
// register access opcodes, upper three bits of the first byte
`define AHC_OP_REGISTER_READ_CMD 3'h1
`define AHC_OP_REGISTER_WRITE_CMD 3'h2

// register map
`define AHC_NREGS 8
`define AHC_REG_ID 3'h0
`define AHC_REG_STATUS 3'h1
`define AHC_REG_GPIO_CFG 3'h6
`define AHC_REG_GPIO_DAT 3'h7
`define AHC_ST_POR_BIT 7
`define AHC_ST_RDYN_BIT 6
`define AHC_REG_RST 8'h00
`define AHC_STATUS_CLEAR 8'h00
// arbitrary identity value
`define AHC_ID_VALUE 8'h5a

// timing
`define AHC_MCLK_NS 100
`define AHC_POWERUP_NS 2200000
`define AHC_POWERUP_CYC ((`AHC_POWERUP_NS + `AHC_MCLK_NS - 1) / `AHC_MCLK_NS)
`define AHC_RESET_WAIT_CLK 4096

// data path
`define AHC_RESULT_BITS 16
`define AHC_FIFO_DEPTH 8

`endif

//--- rtl/ahc_pkg.sv
`default_nettype none

package ahc_pkg;
    typedef logic [15:0] ahc_word_t;
    typedef logic [7:0] ahc_byte_t;
    typedef enum logic [2:0] {
        ls_cmd = 3'b000,
        ls_arg = 3'b001,
        ls_wdata = 3'b010,
        ls_register_read_cmd = 3'b011,
        ls_rdata = 3'b100,
        ls_hold = 3'b101
    } ahc_link_st_t;
endpackage

`default_nettype wire

//--- rtl/ahc_sync3.sv
`default_nettype none

module ahc_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // accept a change only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (q_reg & (s2_reg ^ s3_reg));
        end
    end

    assign q = q_reg;
endmodule // ahc_sync3

`default_nettype wire

//--- rtl/ahc_fifo.sv
`default_nettype none

module ahc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_reg];

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (clr) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            end
            if (push && !pop) begin
                count_reg <= count_reg + (AW+1)'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - (AW+1)'(1);
            end
        end
    end
endmodule // ahc_fifo

`default_nettype wire

//--- dv/ahc_core_props.sv
`default_nettype none
module ahc_core_props (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic data_out_ready_pin,
    input wire logic data_out_ready_oe,
    // control and stream
    input wire logic start_sync_pin,
    input wire logic result_ready_n,
    input wire ahc_pkg::ahc_word_t result_data,
    input wire logic result_valid,
    input wire logic result_accept,
    input wire logic conv_run,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import ahc_pkg::*;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // long enough for any crossing from the link to land
    sequence link_quiet;
        cs_n [*8];
    endsequence
    sequence word_taken;
        result_ready_n && result_valid && result_accept;
    endsequence
    drive_sel_a: assert property (data_out_ready_oe == !cs_n)
        else $error("pin drive does not follow select");
    idle_pin_a: assert property (
        cs_n && $past(cs_n) |-> data_out_ready_pin == result_ready_n)
        else $error("idle pin does not show ready");
    accept_run_a: assert property (result_accept |-> conv_run)
        else $error("word accepted while not converting");
    reset_vals_a: assert property ($rose(nrst) |-> result_ready_n &&
        !result_accept && gpio_out == 4'h0 && gpio_oe == 4'h0)
        else $error("outputs not at reset values");
    pin_run_a: assert property (start_sync_pin [*5] |-> conv_run)
        else $error("start pin high but not converting");
    cmd_only_a: assert property (
        (cs_n && !start_sync_pin) [*8] |-> $stable(conv_run))
        else $error("conversion state moved without command");
    ready_hold_a: assert property (
        (!result_ready_n && cs_n) [*8] |=> !result_ready_n)
        else $error("ready released without a read");
    first_word_a: assert property (
        link_quiet ##0 word_taken |-> ##[1:3] !result_ready_n)
        else $error("new result not flagged");
    cfg_hold_a: assert property (
        link_quiet |-> $stable(gpio_out) && $stable(gpio_oe))
        else $error("gpio moved without a write");
endmodule // ahc_core_props

bind ahc_core ahc_core_props u_props (
    .mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .data_out_ready_pin(data_out_ready_pin),
    .data_out_ready_oe(data_out_ready_oe),
    .start_sync_pin(start_sync_pin), .result_ready_n(result_ready_n),
    .result_data(result_data), .result_valid(result_valid),
    .result_accept(result_accept), .conv_run(conv_run),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe)
);

`default_nettype wire

//--- dv/ahc_spi_host.sv
`default_nettype none
module ahc_spi_host (
    // serial link
    output var logic sclk,
    output var logic cs_n,
    output var logic din,
    input wire logic miso,
    input wire logic miso_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // half period, raised to stall the far side
    realtime half = 7.5;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b1;
    end
    task automatic pause(input int cyc);
        #(cyc * 100);
    endtask
    // low n bits of tx out msb first, clock stays low between frames
    task automatic frame(input int n, input logic [63:0] tx,
                         output logic [63:0] rx);
        rx = '0;
        #($urandom_range(90));
        cs_n = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            din = tx[i];
            #(half);
            sclk = 1'b0;
            rx[i] = miso_oe ? miso : 1'b1;
            #(half);
        end
        #20;
        cs_n = 1'b1;
        din = ~din;
        #40;
    endtask
endmodule // ahc_spi_host
`default_nettype wire

//--- dv/adc_host_command_sequence_test.sv
`include "ahc_params.svh"
`default_nettype none
module adc_host_command_sequence_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ahc_pkg::*;
    localparam int PWR = 50;
    localparam int RWAIT = 20;
    localparam int FD = 8;
    // arbitrary identity value
    localparam logic [7:0] ID = 8'h3c;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic sclk, cs_n, din, pin, pin_oe, start_pin, rdy_n, acc, run, valid;
    logic tl;
    logic [3:0] g_out, g_oe;
    logic [7:0] wb[8], rb[8];
    logic [63:0] rx;
    ahc_word_t sw, w;
    ahc_word_t exp_q[$];
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;
    int got;

    always #50 mclk = ~mclk;

    ahc_core #(.POWERUP_CYC(PWR), .RESET_WAIT(RWAIT), .FIFO_DEPTH(FD),
        .ID_VALUE(ID)) dut (
        .mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .data_out_ready_pin(pin), .data_out_ready_oe(pin_oe),
        .start_sync_pin(start_pin), .result_ready_n(rdy_n),
        .result_data(sw), .result_valid(valid), .result_accept(acc),
        .conv_run(run), .gpio_out(g_out), .gpio_oe(g_oe));
    ahc_spi_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .miso(pin),
        .miso_oe(pin_oe));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic gap(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic cmd(input logic [7:0] op);
        host.frame(8, 64'(op), rx);
        gap(8);
    endtask
    // n registers from address a, address steps per byte
    task automatic regs(input logic wr, input logic [4:0] a, input int n);
        logic [63:0] tx;
        tx = {wr ? `AHC_OP_REGISTER_WRITE_CMD : `AHC_OP_REGISTER_READ_CMD, a, 8'(n - 1)};
        for (int i = 0; i < n; i++) begin
            tx = {tx[55:0], wr ? wb[i] : 8'h00};
        end
        host.frame(16 + 8 * n, tx, rx);
        for (int i = 0; i < n; i++) begin
            rb[i] = rx[8 * (n - 1 - i) +: 8];
        end
        gap(8);
    endtask
    // one clock past the word shows the held lsb
    task automatic rd_word();
        int k;
        k = 0;
        while (rdy_n !== 1'b0 && k < 300) begin
            @(negedge mclk);
            k++;
        end
        chk(rdy_n, 1'b0);
        host.frame(25, 64'(`AHC_OP_RDATA) << 17, rx);
        w = rx[16:1];
        tl = rx[0];
        gap(8);
    endtask
    // word changes only after the edge that took it
    task automatic stream(input int n);
        logic tk;
        tk = 1'b0;
        got = 0;
        sw = 16'h8001;
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            if (tk) begin
                sw = 16'($urandom);
            end
            valid = 1'b1;
            tk = (acc === 1'b1);
            if (tk) begin
                exp_q.push_back(sw);
                got++;
            end
        end
        @(negedge mclk);
        valid = 1'b0;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc >= 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'hbd243fc1));
        start_pin = 1'b0;
        valid = 1'b0;
        sw = 16'h0;
        repeat (6) @(negedge mclk);
        // reset pin held high once released
        nrst = 1'b1;
        gap(2);
        regs(1'b0, `AHC_REG_ID, 2);
        chk(rb[0], ID);
        chk(rb[1], 8'hc0);
        host.pause(PWR);
        regs(1'b0, `AHC_REG_STATUS, 1);
        chk(rb[0], 8'h80);
        wb[0] = 8'h0f;
        regs(1'b1, `AHC_REG_GPIO_CFG, 1);
        chk(g_oe, 4'hf);
        cmd(`AHC_OP_RESET);
        chk(g_oe, 4'h0);
        host.pause(RWAIT);
        wb[0] = 8'h40;
        regs(1'b1, `AHC_REG_STATUS, 1);
        regs(1'b0, `AHC_REG_STATUS, 1);
        chk(rb[0], 8'h80);
        wb[0] = `AHC_STATUS_CLEAR;
        regs(1'b1, `AHC_REG_STATUS, 1);
        regs(1'b0, `AHC_REG_STATUS, 1);
        chk(rb[0], 8'h00);
        for (int i = 0; i < 6; i++) begin
            wb[i] = (i > 3) ? 8'($urandom_range(15)) : 8'($urandom);
        end
        regs(1'b1, 5'h02, 6);
        regs(1'b0, 5'h02, 6);
        for (int i = 0; i < 6; i++) begin
            chk(rb[i], wb[i]);
        end
        chk(g_oe, wb[4][3:0]);
        chk(g_out, wb[5][3:0]);
        wb[0] = 8'h00;
        regs(1'b1, `AHC_REG_GPIO_DAT, 1);
        chk(g_out, 4'h0);
        wb[0] = 8'hff;
        regs(1'b1, 5'h08, 1);
        regs(1'b1, `AHC_REG_ID, 1);
        regs(1'b0, 5'h08, 1);
        chk(rb[0], 8'h00);
        regs(1'b0, `AHC_REG_ID, 1);
        chk(rb[0], ID);
        stream(20);
        chk(16'(got), 16'h0);
        cmd(`AHC_OP_START);
        chk(run, 1'b1);
        stream(30);
        chk(16'(got), 16'(FD + 1));
        host.half = 20.0;
        while (exp_q.size() > 0) begin
            rd_word();
            chk(w, exp_q.pop_front());
            chk(tl, w[0]);
        end
        chk(rdy_n, 1'b1);
        host.half = 7.5;
        host.frame(5, 64'h01, rx);
        gap(8);
        chk(run, 1'b1);
        cmd(`AHC_OP_STOP);
        chk(run, 1'b0);
        start_pin = 1'b1;
        gap(6);
        chk(run, 1'b1);
        start_pin = 1'b0;
        gap(6);
        chk(run, 1'b0);
        tally_and_finish();
    end
endmodule // adc_host_command_sequence_test
`default_nettype wire
